// [hsfs_map.svh]
// Purpose: Register map, field positions and reset values of the fault status bank
// Assumes: 16-bit command codes, byte or word data on the register port
// Notes:   Included by the bank, the power counter and the testbench
// ------------------------------------------------------------------
// Summary of operation
// R1: Overheat fault sets temperature bit 7, latched
// R2: Overheat/underheat warnings set temperature bits 6, 5
// R3: Invalid command code sets communication bit 7
// R4: Invalid data sets communication bit 6
// R5: Bad or missing packet check sets bit 5
// R6: Other communication fault sets communication bit 1
// R7: First to pull alert sets other bit 0
// R8: Enable pin change sets vendor bit 7
// R9: Thermal shutdown latches vendor bit 6
// R10: Supply lockout latches vendor bit 5
// R11: Instant overpower sets vendor bit 4
// R12: Timed overpower expiry sets vendor bit 3
// R13: Bad transistor fault latches vendor bit 2
// R14: Standard copy write-one-clears, mirror write-one-sets
// R15: Reserved status bits always read zero
// R16: Routing bit 1 gates overpower to fault pin
// R17: Routing bit 0 gates overheat to fault pin
// R18: Bad transistor action field bits 7:6, reset 01
// R19: Bad transistor retries bits 5:3, 111 endless
// R20: Host writes 001 into policy low bits
// R21: Counter adds two per over-limit evaluation
// R22: Overpower action bits 4:3, 10 shuts down
// R23: Counter decrements below limit, trips at threshold
// R24: Alert driven low while unmasked status set
// ------------------------------------------------------------------
`ifndef HSFS_MAP_SVH
`define HSFS_MAP_SVH

// Command codes
`define HSFS_A_TEMP_STD   16'h007D
`define HSFS_A_COMM_STD   16'h007E
`define HSFS_A_OTHER_STD  16'h007F
`define HSFS_A_VEND_STD   16'h0080
`define HSFS_A_ROUTING    16'h00D2
`define HSFS_A_FET_POL    16'h00D6
`define HSFS_A_OP_POL     16'h00D7
`define HSFS_A_TEMP_SET   16'hFEC5
`define HSFS_A_COMM_SET   16'hFEC6
`define HSFS_A_VEND_SET   16'hFEC8
`define HSFS_A_TEMP_GATE  16'hFED5
`define HSFS_A_COMM_GATE  16'hFED6
`define HSFS_A_OTHER_SET  16'hFED7
`define HSFS_A_VEND_GATE  16'hFED8
`define HSFS_A_NONE       16'h0000

// Implemented status bits and writable gate bits
`define HSFS_V_TEMP       8'hE0
`define HSFS_V_COMM       8'hE2
`define HSFS_V_OTHER      8'h01
`define HSFS_V_VEND       8'hFC
`define HSFS_GW_TEMP      8'hE0
`define HSFS_GW_COMM      8'hF3
`define HSFS_GW_VEND      8'hFF
`define HSFS_GR_TEMP      8'hE0
`define HSFS_GR_COMM      8'hE3
`define HSFS_GR_VEND      8'hFF

// Configuration reset values and valid bits
`define HSFS_ROUTING_RST  8'h00
`define HSFS_ROUTING_V    8'h03
`define HSFS_FET_POL_RST  8'h41
`define HSFS_OP_POL_RST   16'hFFE0

// Field positions
`define HSFS_RT_OP_BIT    1
`define HSFS_RT_OT_BIT    0
`define HSFS_FET_ACT_MSB  7
`define HSFS_FET_ACT_LSB  6
`define HSFS_FET_RTY_MSB  5
`define HSFS_FET_RTY_LSB  3
`define HSFS_OP_THR_MSB   15
`define HSFS_OP_THR_LSB   5
`define HSFS_OP_ACT_MSB   4
`define HSFS_OP_ACT_LSB   3
`define HSFS_OP_RTY_MSB   2
`define HSFS_OP_RTY_LSB   0

// Field codes
`define HSFS_FETACT_WAIT  2'h1
`define HSFS_OPACT_SHUT   2'h2
`define HSFS_RTY_ENDLESS  3'h7
`define HSFS_CNT_STEP     12'h002

// Synchroniser reset levels, alert line idles high
`define HSFS_SYNC_RST     9'h100

`endif

// [hsfs_pkg.sv]
// Purpose: Types shared by the fault status bank
// Assumes: Nothing
// Notes:   One-hot codes of the gate control machine
`default_nettype none
package hsfs_pkg;
  typedef enum logic [3:0] {
    HSFS_ON    = 4'h1,
    HSFS_DLY   = 4'h2,
    HSFS_OFF   = 4'h4,
    HSFS_LATCH = 4'h8
  } hsfs_gate_state_type;
endpackage
`default_nettype wire

// [hsfs_power_counter.sv]
// Purpose: Timed overpower counter, up by two over the limit, down by one below
// Assumes: eval_i and over_i come from same-clock measurement logic
// Notes:   expired_o is a level while the count stands at or above threshold
`include "hsfs_map.svh"
`default_nettype none
module hsfs_power_counter #(
  parameter int CW = 12
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          arst_n_i,
  // Measurement
  input  wire logic          eval_i,
  input  wire logic          over_i,
  input  wire logic [10:0]   thr_i,
  // Result
  output logic               expired_o
);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          exp_nxt;

  // ------------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------------
  wire logic          at_top  = (cnt_r > ({CW{1'b1}} - `HSFS_CNT_STEP));
  wire logic [CW-1:0] cnt_up  = at_top ? {CW{1'b1}} : cnt_r + `HSFS_CNT_STEP;
  wire logic [CW-1:0] cnt_dn  = (cnt_r == '0) ? '0 : cnt_r - CW'(1);

  assign cnt_nxt = !eval_i ? cnt_r : (over_i ? cnt_up : cnt_dn); // see R21 see R23
  assign exp_nxt = (cnt_nxt >= CW'(thr_i));                      // see R23

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r     <= '0;
      expired_o <= 1'b0;
    end else begin
      cnt_r     <= cnt_nxt;
      expired_o <= exp_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  property p_cnt_up;
    @(posedge clk_i) disable iff (!arst_n_i)
    (eval_i && over_i && !at_top) |=> (cnt_r == $past(cnt_r) + `HSFS_CNT_STEP);
  endproperty
  a_cnt_up: assert property (p_cnt_up) else $error("count did not rise by two"); // see R21

  property p_cnt_dn;
    @(posedge clk_i) disable iff (!arst_n_i)
    (eval_i && !over_i && cnt_r != '0) |=> (cnt_r == $past(cnt_r) - CW'(1));
  endproperty
  a_cnt_dn: assert property (p_cnt_dn) else $error("count did not fall by one"); // see R23

endmodule
`default_nettype wire

// [hsfs_bank.sv]
// Purpose: Fault and warning status bank with alert, fault pin and gate control
// Assumes: Command port from the serial engine on clk_i; detector inputs are async
// Notes:   Set wins over a same-cycle clear on every status bit
`include "hsfs_map.svh"
`default_nettype none
module hsfs_bank #(
  parameter int TW            = 16,
  parameter int FET_DLY_CYC   = 1000,
  parameter int RETRY_DLY_CYC = 4000
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // Register port
  input  wire logic [15:0] reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  // Serial engine events
  input  wire logic        bad_cmd_i,
  input  wire logic        bad_data_i,
  input  wire logic        packet_check_error_i,
  input  wire logic        misc_comm_i,
  // Detectors, asynchronous
  input  wire logic        overheat_fault_i,
  input  wire logic        overheat_warning_i,
  input  wire logic        underheat_warning_i,
  input  wire logic        en_pin_i,
  input  wire logic        thermal_shutdown_i,
  input  wire logic        supply_lockout_i,
  input  wire logic        instant_overpower_i,
  input  wire logic        bad_transistor_i,
  // Timed power evaluation, same clock
  input  wire logic        power_eval_i,
  input  wire logic        over_timed_power_limit_i,
  // Shared alert line, open drain
  input  wire logic        alert_i,
  output logic             alert_o,
  output logic             alert_oe_o,
  // Fault pin and gate
  output logic             fault_output_pin_o,
  output logic             gate_on_o
);

  localparam int NS = 9;
  localparam int NB = 4;
  localparam logic [TW-1:0] FET_DLY   = TW'(FET_DLY_CYC);
  localparam logic [TW-1:0] RETRY_DLY = TW'(RETRY_DLY_CYC);
  localparam logic [NS-1:0] SYNC_RST  = `HSFS_SYNC_RST;
  localparam logic [15:0] STD_A  [NB] = '{`HSFS_A_TEMP_STD, `HSFS_A_COMM_STD,
                                           `HSFS_A_OTHER_STD, `HSFS_A_VEND_STD};
  localparam logic [15:0] SET_A  [NB] = '{`HSFS_A_TEMP_SET, `HSFS_A_COMM_SET,
                                           `HSFS_A_OTHER_SET, `HSFS_A_VEND_SET};
  localparam logic [15:0] GATE_A [NB] = '{`HSFS_A_TEMP_GATE, `HSFS_A_COMM_GATE,
                                           `HSFS_A_NONE, `HSFS_A_VEND_GATE};
  localparam logic [7:0]  VALID  [NB] = '{`HSFS_V_TEMP, `HSFS_V_COMM,
                                           `HSFS_V_OTHER, `HSFS_V_VEND};
  localparam logic [7:0]  GW     [NB] = '{`HSFS_GW_TEMP, `HSFS_GW_COMM,
                                           8'h00, `HSFS_GW_VEND};
  localparam logic [7:0]  GR     [NB] = '{`HSFS_GR_TEMP, `HSFS_GR_COMM,
                                           8'h00, `HSFS_GR_VEND};

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  logic [NS-1:0] async_in;
  logic [NS-1:0] sync1_r;
  logic [NS-1:0] sync2_r;

  assign async_in = {alert_i, bad_transistor_i, instant_overpower_i, supply_lockout_i,
                     thermal_shutdown_i, en_pin_i, underheat_warning_i,
                     overheat_warning_i, overheat_fault_i};

  for (genvar g = 0; g < NS; g++) begin : g_sync
    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        sync1_r[g] <= SYNC_RST[g];
        sync2_r[g] <= SYNC_RST[g];
      end else begin
        sync1_r[g] <= async_in[g];
        sync2_r[g] <= sync1_r[g];
      end
    end
  end

  wire logic ot_s   = sync2_r[0];
  wire logic otw_s  = sync2_r[1];
  wire logic utw_s  = sync2_r[2];
  wire logic en_s   = sync2_r[3];
  wire logic tsd_s  = sync2_r[4];
  wire logic uvlo_s = sync2_r[5];
  wire logic inst_s = sync2_r[6];
  wire logic fet_s  = sync2_r[7];
  wire logic line_s = sync2_r[8];

  logic [1:0] en_arm_r;
  logic       en_d_r;
  logic       en_d_seen_r;

  // Arm only once both synchroniser stages hold the pin: no false change at reset
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      en_arm_r    <= 2'h0;
      en_d_r      <= 1'b0;
      en_d_seen_r <= 1'b0;
    end else begin
      en_arm_r    <= {en_arm_r[0], 1'b1};
      en_d_r      <= en_s;
      en_d_seen_r <= en_arm_r[1];
    end
  end

  wire logic en_chg = en_d_seen_r & (en_s ^ en_d_r);

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------
  logic [NB-1:0] std_hit;
  logic [NB-1:0] set_hit;
  logic [NB-1:0] gate_hit;

  for (genvar i = 0; i < NB; i++) begin : g_dec
    assign std_hit[i]  = (reg_addr_i == STD_A[i]);
    assign set_hit[i]  = (reg_addr_i == SET_A[i]);
    assign gate_hit[i] = (reg_addr_i == GATE_A[i]) & (GR[i] != 8'h00);
  end

  wire logic rt_hit   = (reg_addr_i == `HSFS_A_ROUTING);
  wire logic fet_hit  = (reg_addr_i == `HSFS_A_FET_POL);
  wire logic op_hit   = (reg_addr_i == `HSFS_A_OP_POL);
  wire logic addr_hit = (|std_hit) | (|set_hit) | (|gate_hit) | rt_hit | fet_hit | op_hit;
  wire logic bad_cmd  = bad_cmd_i | ((reg_wr_i | reg_rd_i) & !addr_hit); // see R3

  // ------------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------------
  logic [7:0]  routing_r;
  logic [7:0]  fet_pol_r;
  logic [15:0] op_pol_r;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      routing_r <= `HSFS_ROUTING_RST;
      fet_pol_r <= `HSFS_FET_POL_RST;
      op_pol_r  <= `HSFS_OP_POL_RST;
    end else begin
      if (reg_wr_i && rt_hit) begin
        routing_r <= reg_wdata_i[7:0] & `HSFS_ROUTING_V;
      end
      if (reg_wr_i && fet_hit) begin
        fet_pol_r <= reg_wdata_i[7:0]; // see R20
      end
      if (reg_wr_i && op_hit) begin
        op_pol_r <= reg_wdata_i;
      end
    end
  end

  wire logic [1:0]  fet_act = fet_pol_r[`HSFS_FET_ACT_MSB:`HSFS_FET_ACT_LSB]; // see R18
  wire logic [2:0]  fet_rty = fet_pol_r[`HSFS_FET_RTY_MSB:`HSFS_FET_RTY_LSB]; // see R19
  wire logic [10:0] op_thr  = op_pol_r[`HSFS_OP_THR_MSB:`HSFS_OP_THR_LSB];    // see R21
  wire logic [1:0]  op_act  = op_pol_r[`HSFS_OP_ACT_MSB:`HSFS_OP_ACT_LSB];    // see R22
  wire logic [2:0]  op_rty  = op_pol_r[`HSFS_OP_RTY_MSB:`HSFS_OP_RTY_LSB];

  // ------------------------------------------------------------------
  // Timed overpower counter
  // ------------------------------------------------------------------
  logic timed_exp;

  hsfs_power_counter #(
    .CW (12)
  ) u_power_counter (
    .clk_i     (clk_i),
    .arst_n_i  (arst_n_i),
    .eval_i    (power_eval_i),
    .over_i    (over_timed_power_limit_i),
    .thr_i     (op_thr),
    .expired_o (timed_exp)
  );

  // ------------------------------------------------------------------
  // Status bytes and alert gates
  // ------------------------------------------------------------------
  logic [7:0] stat_r [NB];
  logic [7:0] gate_r [NB];
  logic [7:0] hw_set [NB];
  logic [7:0] stat_nxt [NB];
  logic [7:0] rd_part [NB];
  logic       alert_req;
  logic       alert_drv_r;
  logic       first_evt;

  assign first_evt = alert_req & !alert_drv_r & line_s;                       // see R7
  assign hw_set[0] = {ot_s, otw_s, utw_s, 5'h00};                              // see R1 see R2
  assign hw_set[1] = {bad_cmd, bad_data_i, packet_check_error_i, 3'h0,
                      misc_comm_i, 1'b0};                                       // see R4 see R5 see R6
  assign hw_set[2] = {7'h00, first_evt};
  assign hw_set[3] = {en_chg, tsd_s, uvlo_s, inst_s, timed_exp, fet_s, 2'h0};  // see R8 see R9
                                                                               // see R10 see R11
                                                                               // see R12 see R13

  for (genvar i = 0; i < NB; i++) begin : g_stat
    wire logic [7:0] clr_m = (reg_wr_i & std_hit[i]) ? reg_wdata_i[7:0] : 8'h00;
    wire logic [7:0] set_m = (reg_wr_i & set_hit[i]) ? reg_wdata_i[7:0] : 8'h00;
    // Hardware set wins over a write-one clear in the same cycle
    assign stat_nxt[i] = ((stat_r[i] & ~clr_m) | hw_set[i] | set_m) & VALID[i]; // see R14 see R15
    assign rd_part[i]  = ((std_hit[i] | set_hit[i]) ? stat_r[i] : 8'h00) |
                         (gate_hit[i] ? gate_r[i] : 8'h00);

    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        stat_r[i] <= 8'h00;
        gate_r[i] <= GR[i];
      end else begin
        stat_r[i] <= stat_nxt[i];
        if (reg_wr_i && gate_hit[i]) begin
          gate_r[i] <= (reg_wdata_i[7:0] & GW[i]) | (GR[i] & ~GW[i]);
        end
      end
    end
  end

  // Gate bit of one lets the status bit pull the alert line
  assign alert_req = |((stat_r[0] & gate_r[0]) | (stat_r[1] & gate_r[1]) |
                       (stat_r[3] & gate_r[3]));                               // see R24
  assign alert_o   = 1'b0;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      alert_drv_r <= 1'b0;
    end else begin
      alert_drv_r <= alert_req;
    end
  end

  assign alert_oe_o = alert_drv_r;

  // ------------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------------
  wire logic [15:0] rd_mux = {8'h00, rd_part[0] | rd_part[1] | rd_part[2] | rd_part[3]} |
                             (rt_hit  ? {8'h00, routing_r} : 16'h0000) |
                             (fet_hit ? {8'h00, fet_pol_r} : 16'h0000) |
                             (op_hit  ? op_pol_r           : 16'h0000);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_mux;
    end
  end

  // ------------------------------------------------------------------
  // Fault pin
  // ------------------------------------------------------------------
  wire logic op_flag  = stat_r[3][4] | stat_r[3][3];
  wire logic flt_nxt  = (routing_r[`HSFS_RT_OP_BIT] & op_flag) |      // see R16
                        (routing_r[`HSFS_RT_OT_BIT] & stat_r[0][7]);  // see R17

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fault_output_pin_o <= 1'b0;
    end else begin
      fault_output_pin_o <= flt_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Gate control: fault response and retries
  // ------------------------------------------------------------------
  hsfs_pkg::hsfs_gate_state_type st_r;
  hsfs_pkg::hsfs_gate_state_type st_nxt;
  logic [TW-1:0] tmr_r;
  logic [TW-1:0] tmr_nxt;
  logic [2:0]    used_r;
  logic [2:0]    used_nxt;
  logic          cause_fet_r;
  logic          cause_fet_nxt;
  logic          gate_nxt;

  wire logic       op_trip   = (op_act == `HSFS_OPACT_SHUT) & (inst_s | timed_exp); // see R22
  wire logic       fet_wait  = fet_s & (fet_act == `HSFS_FETACT_WAIT);              // see R18
  wire logic [2:0] allowed   = cause_fet_r ? fet_rty : op_rty;
  wire logic       endless   = (allowed == `HSFS_RTY_ENDLESS);
  wire logic       may_retry = endless | (used_r < allowed);                        // see R19
  wire logic [TW-1:0] tmr_dec = (tmr_r == '0) ? '0 : tmr_r - TW'(1);

  always_comb begin
    st_nxt        = st_r;
    tmr_nxt       = tmr_dec;
    used_nxt      = used_r;
    cause_fet_nxt = cause_fet_r;
    case (st_r)
      hsfs_pkg::HSFS_ON: begin
        if (op_trip) begin
          st_nxt        = hsfs_pkg::HSFS_OFF;
          tmr_nxt       = RETRY_DLY;
          cause_fet_nxt = 1'b0;
        end else if (fet_wait) begin
          st_nxt  = hsfs_pkg::HSFS_DLY;
          tmr_nxt = FET_DLY;
        end
      end
      hsfs_pkg::HSFS_DLY: begin
        if (op_trip) begin
          st_nxt        = hsfs_pkg::HSFS_OFF;
          tmr_nxt       = RETRY_DLY;
          cause_fet_nxt = 1'b0;
        end else if (!fet_s) begin
          st_nxt = hsfs_pkg::HSFS_ON;
        end else if (tmr_r == '0) begin
          st_nxt        = hsfs_pkg::HSFS_OFF;
          tmr_nxt       = RETRY_DLY;
          cause_fet_nxt = 1'b1;
        end
      end
      hsfs_pkg::HSFS_OFF: begin
        if (tmr_r == '0) begin
          if (may_retry) begin
            st_nxt = hsfs_pkg::HSFS_ON;
            if (!endless) begin
              used_nxt = used_r + 3'h1;
            end
          end else begin
            st_nxt = hsfs_pkg::HSFS_LATCH;
          end
        end
      end
      hsfs_pkg::HSFS_LATCH: begin
        if (en_chg) begin
          st_nxt   = hsfs_pkg::HSFS_ON;
          used_nxt = 3'h0;
        end
      end
      default: begin
        st_nxt = hsfs_pkg::HSFS_ON;
      end
    endcase
  end

  assign gate_nxt = en_s & ((st_nxt == hsfs_pkg::HSFS_ON) | (st_nxt == hsfs_pkg::HSFS_DLY));

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r        <= hsfs_pkg::HSFS_ON;
      tmr_r       <= '0;
      used_r      <= 3'h0;
      cause_fet_r <= 1'b0;
      gate_on_o   <= 1'b0;
    end else begin
      st_r        <= st_nxt;
      tmr_r       <= tmr_nxt;
      used_r      <= used_nxt;
      cause_fet_r <= cause_fet_nxt;
      gate_on_o   <= gate_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  property p_ot_latch;
    ot_s ##1 !ot_s |-> stat_r[0][7];
  endproperty
  a_ot_latch: assert property (p_ot_latch) else $error("overheat bit not latched"); // see R1

  property p_warn;
    (otw_s && utw_s) |=> (stat_r[0][6] && stat_r[0][5]);
  endproperty
  a_warn: assert property (p_warn) else $error("temperature warning lost"); // see R2

  property p_bad_cmd;
    (reg_wr_i && !addr_hit) |=> stat_r[1][7];
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("unknown command not flagged"); // see R3

  property p_comm;
    (bad_data_i && packet_check_error_i && misc_comm_i) |=> (stat_r[1] & 8'h62) == 8'h62;
  endproperty
  a_comm: assert property (p_comm) else $error("comm event lost"); // see R4

  property p_en_chg;
    $changed(en_s) && en_d_seen_r |=> stat_r[3][7];
  endproperty
  a_en_chg: assert property (p_en_chg) else $error("enable change not flagged"); // see R8

  property p_w1c;
    (reg_wr_i && std_hit[0] && reg_wdata_i[5] && !utw_s) |=> !stat_r[0][5];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write-one clear failed"); // see R14

  property p_w1s;
    (reg_wr_i && set_hit[3] && reg_wdata_i[6]) |=> stat_r[3][6];
  endproperty
  a_w1s: assert property (p_w1s) else $error("write-one set failed"); // see R14

  property p_resv;
    (stat_r[0][4:0] == 5'h00) && (stat_r[2][7:1] == 7'h00) && (stat_r[3][1:0] == 2'h0);
  endproperty
  a_resv: assert property (p_resv) else $error("reserved status bit set"); // see R15

  property p_flt_ot;
    (routing_r[0] && stat_r[0][7]) |=> fault_output_pin_o;
  endproperty
  a_flt_ot: assert property (p_flt_ot) else $error("overheat not on fault pin"); // see R17

  property p_flt_op;
    (!routing_r[0] && !routing_r[1]) |=> !fault_output_pin_o;
  endproperty
  a_flt_op: assert property (p_flt_op) else $error("fault pin driven ungated"); // see R16

  property p_fet_ignore;
    (st_r == hsfs_pkg::HSFS_ON && fet_act == 2'h0 && !op_trip) |=> st_r == hsfs_pkg::HSFS_ON;
  endproperty
  a_fet_ignore: assert property (p_fet_ignore) else $error("ignored fault acted on"); // see R18

  property p_op_shut;
    (st_r == hsfs_pkg::HSFS_ON && op_trip) |=> ##1 !gate_on_o;
  endproperty
  a_op_shut: assert property (p_op_shut) else $error("overpower did not shut down"); // see R22

  property p_alert;
    alert_req |=> alert_oe_o && !alert_o;
  endproperty
  a_alert: assert property (p_alert) else $error("alert not driven"); // see R24

  c_alert:   cover property (alert_req ##1 first_evt == 1'b0 ##1 stat_r[2][0]);
  c_latch:   cover property (st_r == hsfs_pkg::HSFS_LATCH);
  c_retry:   cover property (st_r == hsfs_pkg::HSFS_OFF ##1 st_r == hsfs_pkg::HSFS_ON);
  c_timed:   cover property (timed_exp && stat_r[3][3]);

endmodule
`default_nettype wire

// [hsfs_host_model.sv]
// Purpose: Host side of the shared open-drain alert wire
// Assumes: Wire has a pull-up
// Notes:   A peer device may pull the wire low too
`default_nettype none
module hsfs_host_model (
  // Wire drivers
  input  wire logic alert_oe_i,
  input  wire logic peer_pull_i,
  // Sensed wire
  output logic      alert_line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  assign alert_line_o = ~(alert_oe_i | peer_pull_i);
endmodule
`default_nettype wire

// [tb.sv]
// Purpose: Register-level test of the fault status bank
// Assumes: Inputs change at the falling edge
// Notes:   Short delay parameters
`include "hsfs_map.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 0, arst_n_i = 0, wr = 0, rd = 0, ev = 0, ovr = 0, peer = 0;
  logic [15:0] addr = 0, wd = 0, rdata;
  logic [3:0]  cm = 0;
  logic [7:0]  det = 8'h08;
  logic        al, ao, oe, fault_output_pin, gate;
  int          n_mismatch = 0, cmp_count = 0;
  always #5 clk_i = ~clk_i;
  hsfs_host_model host_u (.alert_oe_i(oe), .peer_pull_i(peer), .alert_line_o(al));
  hsfs_bank #(.FET_DLY_CYC(5), .RETRY_DLY_CYC(5)) dut_u (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdata), .bad_cmd_i(cm[3]),
    .bad_data_i(cm[2]), .packet_check_error_i(cm[1]), .misc_comm_i(cm[0]),
    .overheat_fault_i(det[0]), .overheat_warning_i(det[1]), .underheat_warning_i(det[2]),
    .en_pin_i(det[3]), .thermal_shutdown_i(det[4]), .supply_lockout_i(det[5]),
    .instant_overpower_i(det[6]), .bad_transistor_i(det[7]), .power_eval_i(ev),
    .over_timed_power_limit_i(ovr), .alert_i(al), .alert_o(ao), .alert_oe_o(oe),
    .fault_output_pin_o(fault_output_pin), .gate_on_o(gate));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk_i);
    addr = a;
    wd = d;
    wr = 1;
    @(negedge clk_i);
    wr = 0;
  endtask
  task automatic rdc(input logic [15:0] a, input logic [15:0] e);
    @(negedge clk_i);
    addr = a;
    rd = 1;
    @(negedge clk_i);
    rd = 0;
    chk(rdata, e);
  endtask
  task automatic pause(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic print_verdict;
    $display("mismatches %0d of %0d compares", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    pause(8);
    arst_n_i = 1;
    pause(5);
    chk(16'(gate), 16'h0001);
    rdc(`HSFS_A_ROUTING, 16'h0000);
    rdc(`HSFS_A_FET_POL, 16'h0041);
    rdc(`HSFS_A_OP_POL, 16'hFFE0);
    rdc(`HSFS_A_COMM_GATE, 16'h00E3);
    wrr(`HSFS_A_FET_POL, 16'h0079);
    rdc(`HSFS_A_FET_POL, 16'h0079);
    cm = 4'hF;
    pause(1);
    cm = 0;
    pause(1);
    chk(16'(oe), 16'h0001);
    rdc(`HSFS_A_COMM_STD, 16'h00E2);
    rdc(`HSFS_A_OTHER_STD, 16'h0001);
    wrr(`HSFS_A_COMM_STD, 16'h00FF);
    rdc(`HSFS_A_COMM_STD, 16'h0000);
    chk(16'(oe), 16'h0000);
    rdc(`HSFS_A_NONE, 16'h0000);
    rdc(`HSFS_A_COMM_STD, 16'h0080);
    wrr(`HSFS_A_COMM_STD, 16'h0080);
    wrr(`HSFS_A_OP_POL, 16'h0070);
    ovr = 1;
    for (int k = 0; k < 2; k++) begin
      ev = 1;
      pause(1);
      ev = 0;
      rdc(`HSFS_A_VEND_STD, (k == 1) ? 16'h0008 : 16'h0000);
    end
    chk(16'(gate), 16'h0000);
    ovr = 0;
    wrr(`HSFS_A_OP_POL, 16'hFFE0);
    wrr(`HSFS_A_VEND_STD, 16'h00FF);
    det = 8'hFF;
    pause(4);
    rdc(`HSFS_A_TEMP_STD, 16'h00E0);
    rdc(`HSFS_A_VEND_STD, 16'h0074);
    chk(16'(fault_output_pin), 16'h0000);
    wrr(`HSFS_A_ROUTING, 16'h0001);
    pause(1);
    chk(16'(fault_output_pin), 16'h0001);
    det = 8'h08;
    pause(4);
    rdc(`HSFS_A_TEMP_STD, 16'h00E0);
    wrr(`HSFS_A_TEMP_STD, 16'h00FF);
    rdc(`HSFS_A_TEMP_STD, 16'h0000);
    chk(16'(fault_output_pin), 16'h0000);
    wrr(`HSFS_A_ROUTING, 16'h0002);
    pause(1);
    chk(16'(fault_output_pin), 16'h0001);
    wrr(`HSFS_A_VEND_STD, 16'h00FF);
    det = 8'h00;
    pause(4);
    rdc(`HSFS_A_VEND_STD, 16'h0080);
    wrr(`HSFS_A_VEND_STD, 16'h00FF);
    wrr(`HSFS_A_TEMP_SET, 16'h00FF);
    rdc(`HSFS_A_TEMP_STD, 16'h00E0);
    chk(16'(oe), 16'h0001);
    wrr(`HSFS_A_TEMP_GATE, 16'h0000);
    pause(1);
    chk(16'(oe), 16'h0000);
    wrr(`HSFS_A_OTHER_STD, 16'h00FF);
    peer = 1;
    pause(3);
    wrr(`HSFS_A_TEMP_GATE, 16'h00E0);
    pause(2);
    rdc(`HSFS_A_OTHER_STD, 16'h0000);
    chk(16'(oe), 16'h0001);
    chk(16'(ao), 16'h0000);
    print_verdict();
  end
endmodule
`default_nettype wire
